// ### dtc_fall_det.sv
// Count-pin sampler: one sample per machine cycle, falling-edge detect.
// Assumes the pin is synchronous to i_clk and i_tick marks machine cycles.
`timescale 1ns/1ps
module dtc_fall_det (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_tick,
    input  wire logic i_pin,
    output logic      o_fall
);
    import dtc_pkg::*;

    logic smp_q;
    logic prev_q;

    // ----------------------------------------------------------------
    // Sampling
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            smp_q  <= 1'b0;
            prev_q <= 1'b0;
        end else if (i_ce && i_tick) begin
            smp_q  <= i_pin;
            prev_q <= smp_q;
        end
    end

    // Held for a whole machine cycle, used on the next tick
    assign o_fall = prev_q & ~smp_q;

endmodule

// ### dtc_monitor.sv
// Checker on the dual timer/counter top-level ports.
// Assumes one clock domain; bound into every dtc_top.
`timescale 1ns/1ps
module dtc_monitor (
    input wire logic                  i_clk,
    input wire logic                  i_rst,
    input wire logic                  i_ce,
    input wire dtc_pkg::dtc_sfr_req_t i_sfr,
    input wire logic                  i_vector_ack_zero,
    input wire logic                  i_vector_ack_one,
    input wire logic                  i_external_interrupt_pin_zero,
    input wire logic                  i_external_interrupt_pin_one,
    input wire logic                  i_count_pin_zero,
    input wire logic                  i_count_pin_one,
    input wire logic [7:0]            o_sfr_rdata,
    input wire logic                  o_overflow_flag_zero,
    input wire logic                  o_overflow_flag_one,
    input wire logic                  o_count_pin_zero,
    input wire logic                  o_count_pin_zero_oe,
    input wire logic                  o_count_pin_one,
    input wire logic                  o_count_pin_one_oe
);
    import dtc_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // ----
    // Properties
    // ----
    property p_reset_vals;
        $fell(i_rst) |-> o_sfr_rdata == RST_BYTE && !o_overflow_flag_zero && !o_overflow_flag_one
            && o_count_pin_zero && o_count_pin_one && !o_count_pin_zero_oe && !o_count_pin_one_oe;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("outputs wrong after reset");
    property p_freeze;
        !i_ce |=> $stable({o_sfr_rdata, o_overflow_flag_zero, o_overflow_flag_one});
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with clock enable low");
    property p_rdata_hold;
        !(i_ce && i_sfr.rd) |=> $stable(o_sfr_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");
    property p_mode_readback;
        i_ce && i_sfr.wr && i_sfr.addr == ADDR_MODE_CFG ##1 !i_sfr.wr
            ##1 i_ce && i_sfr.rd && !i_sfr.wr && i_sfr.addr == ADDR_MODE_CFG
            |=> o_sfr_rdata == $past(i_sfr.wdata, 3);
    endproperty
    a_mode_readback: assert property (p_mode_readback)
        else $error("mode register read back wrong");
    property p_oe_follow;
        i_ce && i_sfr.wr && i_sfr.addr == ADDR_PORT2_MODE ##1 i_ce
            |=> o_count_pin_zero_oe == $past(i_sfr.wdata[PM_TOGGLE_ZERO], 2)
            && o_count_pin_one_oe == $past(i_sfr.wdata[PM_TOGGLE_ONE], 2);
    endproperty
    a_oe_follow: assert property (p_oe_follow)
        else $error("pin drive enable does not follow its bit");
    // Enable lags a cycle, so idle level is judged only after two idle samples
    property p_pin_idle;
        !o_count_pin_zero_oe && !$past(o_count_pin_zero_oe) && $past(i_ce) |-> o_count_pin_zero;
    endproperty
    a_pin_idle: assert property (p_pin_idle)
        else $error("toggle pin not high while disabled");
    property p_ovf_toggle;
        $rose(o_overflow_flag_zero) && o_count_pin_zero_oe && $past(o_count_pin_zero_oe)
            && !$past(i_sfr.wr) |-> o_count_pin_zero != $past(o_count_pin_zero);
    endproperty
    a_ovf_toggle: assert property (p_ovf_toggle)
        else $error("toggle pin missed an overflow");
    // Overflows come only on machine ticks, never on two edges in a row
    property p_flag_ack;
        (i_ce && i_vector_ack_zero)[*2] |=> !o_overflow_flag_zero || $rose(o_overflow_flag_zero);
    endproperty
    a_flag_ack: assert property (p_flag_ack)
        else $error("flag not cleared by vector");
endmodule

bind dtc_top dtc_monitor dtc_monitor_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_sfr(i_sfr),
    .i_vector_ack_zero(i_vector_ack_zero), .i_vector_ack_one(i_vector_ack_one),
    .i_external_interrupt_pin_zero(i_external_interrupt_pin_zero),
    .i_external_interrupt_pin_one(i_external_interrupt_pin_one),
    .i_count_pin_zero(i_count_pin_zero), .i_count_pin_one(i_count_pin_one),
    .o_sfr_rdata(o_sfr_rdata), .o_overflow_flag_zero(o_overflow_flag_zero),
    .o_overflow_flag_one(o_overflow_flag_one), .o_count_pin_zero(o_count_pin_zero),
    .o_count_pin_zero_oe(o_count_pin_zero_oe), .o_count_pin_one(o_count_pin_one),
    .o_count_pin_one_oe(o_count_pin_one_oe)
);

// ### dtc_pin_model.sv
// Far-side model: external count pins and gate pins.
// Assumes count pins idle high through a pull-up; gate pins reset low and follow i_gate.
`timescale 1ns/1ps
module dtc_pin_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [1:0] i_pulse,
    input  wire logic       i_slow,
    input  wire logic [1:0] i_gate,
    output logic      [1:0] o_count_pin,
    output logic      [1:0] o_gate_pin,
    output logic      [1:0] o_busy
);
    logic [4:0] hold_q [2];
    // Low 12 or 18 clocks, then high 12: each level spans a machine cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        for (int k = 0; k < 2; k++) begin
            if (i_rst) begin
                hold_q[k] <= 5'h00;
            end else if (hold_q[k] != 5'h00) begin
                hold_q[k] <= hold_q[k] - 5'h01;
            end else if (i_pulse[k]) begin
                hold_q[k] <= i_slow ? 5'h1E : 5'h18;
            end
        end
    end
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            o_count_pin[k] = !(hold_q[k] > 5'h0C);
            o_busy[k]      = hold_q[k] != 5'h00;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_gate_pin <= 2'b00;
        end else begin
            o_gate_pin <= i_gate;
        end
    end
endmodule

// ### dtc_pkg.sv
// Package for the dual timer/counter: register offsets, field positions,
// reset values, mode encoding and the register-port carrier.
// Assumes a single 100 MHz clock domain and an 8-bit special register port.
package dtc_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'h88;
    localparam logic [7:0] ADDR_MODE_CFG    = 8'h89;
    localparam logic [7:0] ADDR_LOW_ZERO    = 8'h8A;
    localparam logic [7:0] ADDR_LOW_ONE     = 8'h8B;
    localparam logic [7:0] ADDR_HIGH_ZERO   = 8'h8C;
    localparam logic [7:0] ADDR_HIGH_ONE    = 8'h8D;
    localparam logic [7:0] ADDR_PORT2_MODE  = 8'hA4;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CS_FLAG_ONE  = 7;
    localparam int CS_RUN_ONE   = 6;
    localparam int CS_FLAG_ZERO = 5;
    localparam int CS_RUN_ZERO  = 4;
    localparam int MC_GATE_ONE  = 7;
    localparam int MC_SEL_ONE   = 6;
    localparam int MC_MODE_ONE  = 4;
    localparam int MC_GATE_ZERO = 3;
    localparam int MC_SEL_ZERO  = 2;
    localparam int MC_MODE_ZERO = 0;
    localparam int PM_TOGGLE_ZERO = 0;
    localparam int PM_TOGGLE_ONE  = 1;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam int         MC_CLKS    = 6;
    localparam logic [2:0] MC_LAST    = 3'(MC_CLKS - 1);
    localparam logic [7:0] BYTE_ONES  = 8'hFF;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_RELOAD,
        MODE_SPLIT
    } dtc_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } dtc_sfr_req_t;

    typedef struct packed {
        logic       ovf;
        logic [7:0] th;
        logic [7:0] tl;
    } dtc_step_t;

endpackage

// ### dtc_top.sv
// Dual timer/counter: two up-counters with four modes, flags, toggle outputs.
// Assumes software reaches it through the 8-bit special register port and
// that the count and gate pins are synchronous to i_clk.
`timescale 1ns/1ps
module dtc_top (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_ce,
    input  wire dtc_pkg::dtc_sfr_req_t i_sfr,
    input  wire logic                  i_vector_ack_zero,
    input  wire logic                  i_vector_ack_one,
    input  wire logic                  i_external_interrupt_pin_zero,
    input  wire logic                  i_external_interrupt_pin_one,
    input  wire logic                  i_count_pin_zero,
    input  wire logic                  i_count_pin_one,
    output logic [7:0]                 o_sfr_rdata,
    output logic                       o_overflow_flag_zero,
    output logic                       o_overflow_flag_one,
    output logic                       o_count_pin_zero,
    output logic                       o_count_pin_zero_oe,
    output logic                       o_count_pin_one,
    output logic                       o_count_pin_one_oe
);
    import dtc_pkg::*;

    // ----------------------------------------------------------------
    // Step function shared by both timers
    // ----------------------------------------------------------------
    function automatic dtc_step_t step(input dtc_mode_t m, input logic [7:0] th,
                                       input logic [7:0] tl);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0]  s8;
        dtc_step_t   r;
        s13 = {1'b0, th, tl[4:0]} + 14'h0001;
        s16 = {1'b0, th, tl} + 17'h0_0001;
        s8  = {1'b0, tl} + 9'h001;
        r   = '{ovf: 1'b0, th: th, tl: tl};
        unique case (m)
            MODE_13BIT: begin
                r = '{ovf: s13[13], th: s13[12:5], tl: {tl[7:5], s13[4:0]}};
            end
            MODE_16BIT: begin
                r = '{ovf: s16[16], th: s16[15:8], tl: s16[7:0]};
            end
            MODE_RELOAD: begin
                r = '{ovf: s8[8], th: th, tl: s8[8] ? th : s8[7:0]};
            end
            MODE_SPLIT: begin
                r = '{ovf: s8[8], th: th, tl: s8[7:0]};
            end
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [2:0] mc_cnt_q;
    logic       tick;
    logic [7:0] mode_cfg_q;
    logic [7:0] tl0_q;
    logic [7:0] th0_q;
    logic [7:0] tl1_q;
    logic [7:0] th1_q;
    logic       run_bit_zero_q;
    logic       run_bit_one_q;
    logic       tog_en0_q;
    logic       tog_en1_q;
    logic       fall0;
    logic       fall1;
    dtc_mode_t  mode0;
    dtc_mode_t  mode1;
    dtc_step_t  nx0;
    dtc_step_t  nx1;
    logic       en0;
    logic       en1;
    logic       en_th0;
    logic       ovf0;
    logic       ovf1;
    logic       ovf_th0;
    logic       set_flag0;
    logic       set_flag1;
    logic       wr;

    assign wr = i_sfr.wr;

    // ----------------------------------------------------------------
    // Machine cycle prescaler
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mc_cnt_q <= '0;
        end else if (i_ce) begin
            mc_cnt_q <= (mc_cnt_q == MC_LAST) ? 3'd0 : mc_cnt_q + 3'd1;
        end
    end
    assign tick = (mc_cnt_q == MC_LAST);

    // ----------------------------------------------------------------
    // Count pin sampling
    // ----------------------------------------------------------------
    // Source must hold each level a machine cycle or edges are missed
    dtc_fall_det u_fall0 (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_ce   (i_ce),
        .i_tick (tick),
        .i_pin  (i_count_pin_zero),
        .o_fall (fall0)
    );
    dtc_fall_det u_fall1 (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_ce   (i_ce),
        .i_tick (tick),
        .i_pin  (i_count_pin_one),
        .o_fall (fall1)
    );

    // ----------------------------------------------------------------
    // Count enables and overflow
    // ----------------------------------------------------------------
    assign mode0 = dtc_mode_t'(mode_cfg_q[MC_MODE_ZERO +: 2]);
    assign mode1 = dtc_mode_t'(mode_cfg_q[MC_MODE_ONE +: 2]);
    assign nx0   = step(mode0, th0_q, tl0_q);
    assign nx1   = step(mode1, th1_q, tl1_q);

    assign en0 = tick & run_bit_zero_q
               & (~mode_cfg_q[MC_GATE_ZERO] | i_external_interrupt_pin_zero)
               & (~mode_cfg_q[MC_SEL_ZERO] | fall0);
    assign en1 = tick & run_bit_one_q & (mode1 != MODE_SPLIT)
               & (~mode_cfg_q[MC_GATE_ONE] | i_external_interrupt_pin_one)
               & (~mode_cfg_q[MC_SEL_ONE] | fall1);
    // Split mode: high byte of timer zero borrows the run bit of timer one
    assign en_th0  = tick & run_bit_one_q & (mode0 == MODE_SPLIT);
    assign ovf0    = en0 & nx0.ovf;
    assign ovf1    = en1 & nx1.ovf;
    assign ovf_th0 = en_th0 & (th0_q == BYTE_ONES);
    assign set_flag0 = ovf0;
    // Timer one keeps counting for baud use but loses its flag
    assign set_flag1 = (mode0 == MODE_SPLIT) ? ovf_th0 : ovf1;

    // ----------------------------------------------------------------
    // Count registers; software write wins over a count
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tl0_q <= RST_BYTE;
            th0_q <= RST_BYTE;
        end else if (i_ce) begin
            if (wr && i_sfr.addr == ADDR_LOW_ZERO) begin
                tl0_q <= i_sfr.wdata;
            end else if (en0) begin
                tl0_q <= nx0.tl;
            end
            if (wr && i_sfr.addr == ADDR_HIGH_ZERO) begin
                th0_q <= i_sfr.wdata;
            end else if (en_th0) begin
                th0_q <= th0_q + 8'h01;
            end else if (en0) begin
                th0_q <= nx0.th;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tl1_q <= RST_BYTE;
            th1_q <= RST_BYTE;
        end else if (i_ce) begin
            if (wr && i_sfr.addr == ADDR_LOW_ONE) begin
                tl1_q <= i_sfr.wdata;
            end else if (en1) begin
                tl1_q <= nx1.tl;
            end
            if (wr && i_sfr.addr == ADDR_HIGH_ONE) begin
                th1_q <= i_sfr.wdata;
            end else if (en1) begin
                th1_q <= nx1.th;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_cfg_q     <= RST_BYTE;
            run_bit_zero_q <= 1'b0;
            run_bit_one_q  <= 1'b0;
            tog_en0_q      <= 1'b0;
            tog_en1_q      <= 1'b0;
        end else if (i_ce && wr) begin
            if (i_sfr.addr == ADDR_MODE_CFG) begin
                mode_cfg_q <= i_sfr.wdata;
            end
            if (i_sfr.addr == ADDR_CTRL_STATUS) begin
                // Only gates counting; count bytes untouched
                run_bit_zero_q <= i_sfr.wdata[CS_RUN_ZERO];
                run_bit_one_q  <= i_sfr.wdata[CS_RUN_ONE];
            end
            if (i_sfr.addr == ADDR_PORT2_MODE) begin
                tog_en0_q <= i_sfr.wdata[PM_TOGGLE_ZERO];
                tog_en1_q <= i_sfr.wdata[PM_TOGGLE_ONE];
            end
        end
    end

    // ----------------------------------------------------------------
    // Overflow flags: hardware set beats any clear
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_overflow_flag_zero <= 1'b0;
            o_overflow_flag_one  <= 1'b0;
        end else if (i_ce) begin
            if (set_flag0) begin
                o_overflow_flag_zero <= 1'b1;
            end else if (i_vector_ack_zero) begin
                o_overflow_flag_zero <= 1'b0;
            end else if (wr && i_sfr.addr == ADDR_CTRL_STATUS) begin
                o_overflow_flag_zero <= i_sfr.wdata[CS_FLAG_ZERO];
            end
            if (set_flag1) begin
                o_overflow_flag_one <= 1'b1;
            end else if (i_vector_ack_one) begin
                o_overflow_flag_one <= 1'b0;
            end else if (wr && i_sfr.addr == ADDR_CTRL_STATUS) begin
                o_overflow_flag_one <= i_sfr.wdata[CS_FLAG_ONE];
            end
        end
    end

    // ----------------------------------------------------------------
    // Toggle outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_count_pin_zero    <= 1'b1;
            o_count_pin_one     <= 1'b1;
            o_count_pin_zero_oe <= 1'b0;
            o_count_pin_one_oe  <= 1'b0;
        end else if (i_ce) begin
            o_count_pin_zero_oe <= tog_en0_q;
            o_count_pin_one_oe  <= tog_en1_q;
            if (!tog_en0_q) begin
                o_count_pin_zero <= 1'b1;
            end else if (ovf0) begin
                o_count_pin_zero <= ~o_count_pin_zero;
            end
            if (!tog_en1_q) begin
                o_count_pin_one <= 1'b1;
            end else if (ovf1) begin
                o_count_pin_one <= ~o_count_pin_one;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sfr_rdata <= RST_BYTE;
        end else if (i_ce && i_sfr.rd) begin
            unique case (i_sfr.addr)
                ADDR_CTRL_STATUS: o_sfr_rdata <= {o_overflow_flag_one, run_bit_one_q,
                                                  o_overflow_flag_zero, run_bit_zero_q, 4'h0};
                ADDR_MODE_CFG:    o_sfr_rdata <= mode_cfg_q;
                ADDR_LOW_ZERO:    o_sfr_rdata <= tl0_q;
                ADDR_LOW_ONE:     o_sfr_rdata <= tl1_q;
                ADDR_HIGH_ZERO:   o_sfr_rdata <= th0_q;
                ADDR_HIGH_ONE:    o_sfr_rdata <= th1_q;
                ADDR_PORT2_MODE:  o_sfr_rdata <= {6'h00, tog_en1_q, tog_en0_q};
                default:          o_sfr_rdata <= RST_BYTE;
            endcase
        end
    end

endmodule

// ### tb.sv
// Self-checking bench for the dual timer/counter.
// Assumes the pin model on the count and gate pins.
`timescale 1ns/1ps
module tb;
    import dtc_pkg::*;
    typedef struct {
        logic [7:0] a;
        logic [7:0] e;
        logic [7:0] m;
    } dtc_note_t;
    logic         i_clk    = 1'b0;
    logic         i_rst    = 1'b1;
    logic         i_ce     = 1'b1;
    dtc_sfr_req_t sfr      = '0;
    logic [1:0]   ack      = 2'b00;
    logic [1:0]   pulse    = 2'b00;
    logic [1:0]   gate     = 2'b00;
    logic         slow     = 1'b0;
    logic [1:0]   mpin;
    logic [1:0]   mgate;
    logic [1:0]   mbusy;
    logic [7:0]   rdata;
    logic [1:0]   flag;
    logic [1:0]   pin;
    logic [1:0]   oe;
    wire  [1:0]   cpin     = {oe[1] ? pin[1] : mpin[1], oe[0] ? pin[0] : mpin[0]};
    dtc_note_t    notes[$];
    int           errors   = 0;
    int           n_checks = 0;
    int           seed     = 32'h428b_496b;
    logic [7:0]   v;
    logic [7:0]   mh [3]   = '{8'hFF, 8'hFF, 8'hF0};
    logic [7:0]   ml [3]   = '{8'h1E, 8'hFE, 8'hFE};
    logic [7:0]   el [3]   = '{8'h01, 8'h01, 8'hF1};
    logic [7:0]   mk [3]   = '{8'h1F, 8'hFF, 8'hFF};
    always #5 i_clk = ~i_clk;
    dtc_top dtc_top_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_sfr(sfr),
        .i_vector_ack_zero(ack[0]), .i_vector_ack_one(ack[1]),
        .i_external_interrupt_pin_zero(mgate[0]), .i_external_interrupt_pin_one(mgate[1]),
        .i_count_pin_zero(cpin[0]), .i_count_pin_one(cpin[1]), .o_sfr_rdata(rdata),
        .o_overflow_flag_zero(flag[0]), .o_overflow_flag_one(flag[1]),
        .o_count_pin_zero(pin[0]), .o_count_pin_zero_oe(oe[0]),
        .o_count_pin_one(pin[1]), .o_count_pin_one_oe(oe[1])
    );
    dtc_pin_model dtc_pin_model_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_pulse(pulse), .i_slow(slow), .i_gate(gate),
        .o_count_pin(mpin), .o_gate_pin(mgate), .o_busy(mbusy)
    );
    task automatic close_out;
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // One request, taken at the second edge, then released
    task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d,
                       input logic [7:0] m);
        @(posedge i_clk);
        #1;
        sfr = '{addr: a, wr: w, rd: !w, wdata: w ? d : 8'h00};
        if (!w) notes.push_back('{a: a, e: d & m, m: m});
        @(posedge i_clk);
        #1;
        sfr = '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, 1'b1, d, 8'hFF);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        acc(a, 1'b0, e, m);
    endtask
    // Exactly n ticks fall between the start and stop writes
    task automatic run(input logic [7:0] on, input int n, input logic [1:0] ef);
        wr(ADDR_CTRL_STATUS, on);
        repeat (6 * n - 2) @(posedge i_clk);
        #1;
        chk("flags", {6'h00, ef}, {6'h00, flag});
        wr(ADDR_CTRL_STATUS, 8'h00);
    endtask
    task automatic load(input logic [7:0] mode, input logic [7:0] hi, input logic [7:0] lo);
        wr(ADDR_MODE_CFG, mode);
        wr(ADDR_HIGH_ZERO, hi);
        wr(ADDR_LOW_ZERO, lo);
    endtask
    // ----
    // Read-data scoreboard
    // ----
    always @(posedge i_clk) begin
        if (i_ce && sfr.rd) begin
            #2;
            chk($sformatf("read %h", notes[0].a), notes[0].e, rdata & notes[0].m);
            void'(notes.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        close_out;
    end
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (20) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        rd(ADDR_CTRL_STATUS, 8'h00);
        rd(ADDR_MODE_CFG, 8'h00);
        v = 8'($random(seed));
        wr(ADDR_MODE_CFG, v);
        rd(ADDR_MODE_CFG, v);
        rd(8'h90, 8'h00);
        wr(ADDR_CTRL_STATUS, 8'h0F);
        rd(ADDR_CTRL_STATUS, 8'h00);
        v = 8'($random(seed)) & 8'h7F;
        load(8'h01, 8'h00, v);
        run(8'h10, 5, 2'b00);
        run(8'h10, 5, 2'b00);
        rd(ADDR_LOW_ZERO, v + 8'h0A);
        rd(ADDR_HIGH_ZERO, 8'h00);
        wr(ADDR_PORT2_MODE, 8'h01);
        @(posedge i_clk);
        #1;
        chk("toggle", 8'h03, {6'h00, oe[0], pin[0]});
        for (int k = 0; k < 3; k++) begin
            load(8'(k), mh[k], ml[k]);
            run(8'h10, 3, 2'b01);
            rd(ADDR_LOW_ZERO, el[k], mk[k]);
            rd(ADDR_HIGH_ZERO, mh[k] & 8'hF0 & {8{k == 2}});
        end
        chk("toggle", 8'h02, {6'h00, oe[0], pin[0]});
        wr(ADDR_PORT2_MODE, 8'h00);
        wr(ADDR_CTRL_STATUS, 8'hA0);
        rd(ADDR_CTRL_STATUS, 8'hA0);
        @(posedge i_clk);
        #1;
        ack = 2'b11;
        repeat (2) @(posedge i_clk);
        #1;
        ack = 2'b00;
        chk("flags", 8'h00, {6'h00, flag});
        load(8'h09, 8'h00, 8'h00);
        run(8'h10, 3, 2'b00);
        gate = 2'b01;
        run(8'h10, 3, 2'b00);
        rd(ADDR_LOW_ZERO, 8'h03);
        v = 8'($random(seed));
        load(8'h33, 8'hFE, v);
        wr(ADDR_LOW_ONE, v);
        run(8'h40, 4, 2'b10);
        rd(ADDR_HIGH_ZERO, 8'h02);
        rd(ADDR_LOW_ZERO, v);
        rd(ADDR_LOW_ONE, v);
        wr(ADDR_PORT2_MODE, 8'h02);
        wr(ADDR_MODE_CFG, 8'h10);
        wr(ADDR_HIGH_ONE, 8'hFF);
        wr(ADDR_LOW_ONE, 8'hFE);
        run(8'h40, 3, 2'b10);
        rd(ADDR_LOW_ONE, 8'h01);
        rd(ADDR_HIGH_ONE, 8'h00);
        chk("toggle one", 8'h02, {6'h00, oe[1], pin[1]});
        wr(ADDR_PORT2_MODE, 8'h00);
        load(8'h05, 8'h00, 8'h00);
        wr(ADDR_CTRL_STATUS, 8'h10);
        for (int k = 0; k < 3; k++) begin
            slow = 1'(k);
            pulse = 2'b01;
            @(posedge i_clk);
            #1;
            pulse = 2'b00;
            for (int t = 0; t < 40 && mbusy[0]; t++) begin
                @(posedge i_clk);
                #1;
            end
            if (mbusy[0]) begin
                errors++;
                close_out;
            end
        end
        repeat (24) @(posedge i_clk);
        wr(ADDR_CTRL_STATUS, 8'h00);
        rd(ADDR_LOW_ZERO, 8'h03);
        i_ce = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        i_ce = 1'b1;
        rd(ADDR_LOW_ZERO, 8'h03);
        close_out;
    end
endmodule
